// ==== spx_map.svh ====
// register layout and constants of the paging address extension
`ifndef SPX_MAP_SVH
`define SPX_MAP_SVH

`define SPX_PAGE_LSB     0
`define SPX_PAGE_MSB     2
`define SPX_STORAGE_SLOT_NUMBER_LSB     4
`define SPX_STORAGE_SLOT_NUMBER_MSB     5
`define SPX_CODE_LSB     6
`define SPX_CODE_MSB     7
`define SPX_PAGE_RESET   3'h0
`define SPX_SLOT_RESET   3'h0
`define SPX_MAP_RESET    1'h0
`define SPX_NUM_MODULES  4
`define SPX_NUM_SLOTS    4
`define SPX_MOD_PORT     2'h0
`define SPX_MOD_ADC      2'h1
`define SPX_MOD_CCU      2'h2
`define SPX_MOD_SYSCON   2'h3
`define SPX_MAP_BIT      0

`endif

// ==== spx_pkg.sv ====
// types shared by both ends of the paging address extension
`default_nettype none
package spx_pkg;
  typedef logic [2:0] spx_page_t;
  typedef logic [1:0] spx_slot_t;
  typedef logic [1:0] spx_mod_t;
  typedef enum logic [1:0] {
    SPX_OP_PLAIN0  = 2'b00,
    SPX_OP_PLAIN1  = 2'b01,
    SPX_OP_SAVE    = 2'b10,
    SPX_OP_RESTORE = 2'b11
  } spx_op_t;
  typedef enum logic [1:0] {
    SPX_H_IDLE  = 2'b00,
    SPX_H_WRITE = 2'b01,
    SPX_H_READ  = 2'b10,
    SPX_H_MAP   = 2'b11
  } spx_hstate_t;
endpackage
`default_nettype wire

// ==== spx_if.sv ====
// register bus between the core and the paging block
`default_nettype none
interface spx_if;
  logic       wr_en;    // page register write strobe
  logic       rd_en;    // page register read strobe
  logic [1:0] mod_sel;  // which module page register
  logic [7:0] wdata;    // write data
  logic [7:0] rdata;    // read data, valid cycle after rd_en
  logic       map_wr;   // control register write strobe
  logic       map_wdata;// new mapped-area select value
  logic       map_sel;  // current mapped-area select
  modport dev (input wr_en, rd_en, mod_sel, wdata, map_wr, map_wdata,
               output rdata, map_sel);
  modport core (output wr_en, rd_en, mod_sel, wdata, map_wr, map_wdata,
                input rdata, map_sel);
endinterface
`default_nettype wire

// ==== spx_dev.sv ====
// paging and mapped-area extension, device end
`include "spx_map.svh"
`default_nettype none
// Function
// - set select bit steers to mapped area
// - select bit holds until software writes
// - software sets select before accessing area
// - software changes select read-modify-write only
// - software writes page before other-page access
// - page field takes write, reads active
// - read returns currently active page
// - four storage slots per page register
// - bits 5:4 pick the slot
// - code 10 saves page then loads new
// - code 11 restores page from slot
// - restore ignores written page bits
// - registers for ports, adc, ccu, syscon
// - interrupt code saves on entry, restores
module spx_dev
  import spx_pkg::*;
(
  input  wire logic      clk_in,         // system clock
  input  wire logic      rst_n_in,       // async reset, active low
  spx_if.dev             bus,            // register bus from core
  output logic           map_area_out,   // high: mapped area selected
  output spx_page_t      port_page_out,  // active page, parallel ports
  output spx_page_t      adc_page_out,   // active page, converter
  output spx_page_t      ccu_page_out,   // active page, capture compare
  output spx_page_t      sys_page_out    // active page, system control
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  spx_page_t page_q [`SPX_NUM_MODULES];
  spx_page_t page_d [`SPX_NUM_MODULES];
  spx_page_t slot_q [`SPX_NUM_MODULES][`SPX_NUM_SLOTS];
  spx_page_t slot_d [`SPX_NUM_MODULES][`SPX_NUM_SLOTS];
  logic       map_q;
  logic       map_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  spx_op_t   op;
  spx_slot_t slot_no;
  spx_page_t new_page;
  assign op       = spx_op_t'(bus.wdata[`SPX_CODE_MSB:`SPX_CODE_LSB]);
  assign slot_no  = bus.wdata[`SPX_STORAGE_SLOT_NUMBER_MSB:`SPX_STORAGE_SLOT_NUMBER_LSB];
  assign new_page = bus.wdata[`SPX_PAGE_MSB:`SPX_PAGE_LSB];

  // next state of pages, slots, select bit and read data
  always_comb begin
    page_d  = page_q;
    slot_d  = slot_q;
    map_d   = map_q;
    rdata_d = rdata_q;
    if (bus.map_wr) begin
      map_d = bus.map_wdata;
    end
    if (bus.wr_en) begin
      case (op)
        SPX_OP_SAVE: begin
          slot_d[bus.mod_sel][slot_no] = page_q[bus.mod_sel];
          page_d[bus.mod_sel]          = new_page;
        end
        SPX_OP_RESTORE: begin
          page_d[bus.mod_sel] = slot_q[bus.mod_sel][slot_no];
        end
        default: begin
          page_d[bus.mod_sel] = new_page;
        end
      endcase
    end
    if (bus.rd_en) begin
      rdata_d = {5'h00, page_q[bus.mod_sel]};
    end
  end

  // registers, all cleared at reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int m = 0; m < `SPX_NUM_MODULES; m++) begin
        page_q[m] <= `SPX_PAGE_RESET;
        for (int s = 0; s < `SPX_NUM_SLOTS; s++) begin
          slot_q[m][s] <= `SPX_SLOT_RESET;
        end
      end
      map_q   <= `SPX_MAP_RESET;
      rdata_q <= 8'h00;
    end else begin
      page_q  <= page_d;
      slot_q  <= slot_d;
      map_q   <= map_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------
  assign bus.rdata     = rdata_q;
  assign bus.map_sel   = map_q;
  assign map_area_out  = map_q;
  assign port_page_out = page_q[`SPX_MOD_PORT];
  assign adc_page_out  = page_q[`SPX_MOD_ADC];
  assign ccu_page_out  = page_q[`SPX_MOD_CCU];
  assign sys_page_out  = page_q[`SPX_MOD_SYSCON];

endmodule
`default_nettype wire

// ==== spx_core.sv ====
// paging and mapped-area extension, core end issuing bus accesses
`include "spx_map.svh"
`default_nettype none
module spx_core
  import spx_pkg::*;
(
  input  wire logic      clk_in,      // system clock
  input  wire logic      rst_n_in,    // async reset, active low
  spx_if.core            bus,         // register bus to device
  input  wire logic      req_in,      // one-cycle request pulse
  input  wire logic [1:0] kind_in,    // 0 write, 1 read, 2 set map, 3 clear map
  input  wire spx_mod_t  mod_in,      // target module
  input  wire logic [7:0] data_in,    // page register write value
  output logic           busy_out,    // request in progress
  output logic           done_out,    // one-cycle completion pulse
  output logic [7:0]     rdata_out    // last page read
);

  spx_hstate_t st_q, st_d;
  logic       wr_q, wr_d, rd_q, rd_d, mw_q, mw_d, mv_q, mv_d;
  logic       done_q, done_d;
  logic       rdp_q, rdp_d;    // read data due in the closing state
  logic [1:0] mod_q, mod_d;
  logic [7:0] wd_q, wd_d, rdo_q, rdo_d;

  // request sequencer: one strobe, then answer
  always_comb begin
    st_d = st_q; wr_d = 1'b0; rd_d = 1'b0; mw_d = 1'b0; mv_d = mv_q;
    done_d = 1'b0; mod_d = mod_q; wd_d = wd_q; rdo_d = rdo_q;
    rdp_d = 1'b0;
    case (st_q)
      SPX_H_IDLE: begin
        if (req_in) begin
          mod_d = mod_in;
          wd_d  = data_in;
          case (kind_in)
            2'h0: begin wr_d = 1'b1; st_d = SPX_H_WRITE; end
            2'h1: begin rd_d = 1'b1; st_d = SPX_H_READ; end
            // read-modify-write of the select bit only
            default: begin
              mw_d = 1'b1;
              mv_d = (kind_in == 2'h2) ? (bus.map_sel | 1'b1) : (bus.map_sel & 1'b0);
              st_d = SPX_H_MAP;
            end
          endcase
        end
      end
      // read data lands one cycle after the strobe
      SPX_H_READ: begin
        rdp_d = 1'b1;
        st_d  = SPX_H_WRITE;
      end
      SPX_H_WRITE: begin
        if (rdp_q) begin
          rdo_d = bus.rdata;
        end
        done_d = 1'b1;
        st_d   = SPX_H_IDLE;
      end
      SPX_H_MAP: begin
        done_d = 1'b1;
        st_d   = SPX_H_IDLE;
      end
      default: st_d = SPX_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= SPX_H_IDLE; wr_q <= 1'b0; rd_q <= 1'b0; mw_q <= 1'b0;
      mv_q <= 1'b0; done_q <= 1'b0; mod_q <= 2'h0; wd_q <= 8'h00;
      rdo_q <= 8'h00;
      rdp_q <= 1'b0;
    end else begin
      st_q <= st_d; wr_q <= wr_d; rd_q <= rd_d; mw_q <= mw_d;
      mv_q <= mv_d; done_q <= done_d; mod_q <= mod_d; wd_q <= wd_d;
      rdo_q <= rdo_d;
      rdp_q <= rdp_d;
    end
  end

  assign bus.wr_en     = wr_q;
  assign bus.rd_en     = rd_q;
  assign bus.mod_sel   = mod_q;
  assign bus.wdata     = wd_q;
  assign bus.map_wr    = mw_q;
  assign bus.map_wdata = mv_q;
  assign busy_out      = (st_q != SPX_H_IDLE);
  assign done_out      = done_q;
  assign rdata_out     = rdo_q;

endmodule
`default_nettype wire

// ==== spx_checker.sv ====
// concurrent checks on the paging register bus
`default_nettype none
module spx_checker
  import spx_pkg::*;
(
  input wire logic       clk_in,    // system clock
  input wire logic       rst_n_in,  // async reset, active low
  input wire logic       wr_en,     // write strobe
  input wire logic       rd_en,     // read strobe
  input wire logic [1:0] mod_sel,   // module select
  input wire logic [7:0] wdata,     // write data
  input wire logic [7:0] rdata,     // read data
  input wire logic       map_wr,    // select write strobe
  input wire logic       map_wdata, // select write value
  input wire logic       map_sel    // current select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [2:0] pg_q[4];
  logic [2:0] st_q[4][4];
  // shadow of pages and slots
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pg_q <= '{default: 3'h0};
      st_q <= '{default: '{default: 3'h0}};
    end else if (wr_en) begin
      if (wdata[7:6] == 2'b10) st_q[mod_sel][wdata[5:4]] <= pg_q[mod_sel];
      pg_q[mod_sel] <= (wdata[7:6] == 2'b11) ? st_q[mod_sel][wdata[5:4]] : wdata[2:0];
    end
  end
  a_map_write: assert property (map_wr |=> map_sel == $past(map_wdata))
    else $error("select bit missed its write");
  a_map_hold: assert property (!map_wr |=> $stable(map_sel))
    else $error("select bit changed without a write");
  a_rd_page: assert property (rd_en |=> rdata == {5'h0, $past(pg_q[mod_sel])})
    else $error("read data is not the active page");
  a_rd_upper_zero: assert property (rd_en |=> rdata[7:3] == 5'h0)
    else $error("upper read bits not zero");
  a_rd_stands: assert property (!rd_en |=> $stable(rdata))
    else $error("read data moved without a read");
  a_wr_pulse: assert property (wr_en |=> !wr_en)
    else $error("write strobe longer than one cycle");
  a_rd_pulse: assert property (rd_en |=> !rd_en)
    else $error("read strobe longer than one cycle");
  a_one_strobe: assert property (wr_en |-> !rd_en && !map_wr)
    else $error("two strobes at once");
endmodule
`default_nettype wire

// ==== tb_sfr_paging_address_extension.sv ====
// testbench for both ends of the paging extension
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module tb_sfr_paging_address_extension
  import spx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_n_in = 0, req = 0, map, busy, done;
  logic [1:0] kind = 0;
  spx_mod_t mod = 0;
  logic [7:0] data = 0, rdo;
  spx_page_t pp, pa, pc, ps;
  wire logic [11:0] pv = {ps, pc, pa, pp};
  int miscompares = 0, num_checks = 0;
  always #2 clk_in = ~clk_in;
  spx_if bus_if();
  spx_dev u_spx_dev(.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus_if), .map_area_out(map),
    .port_page_out(pp), .adc_page_out(pa), .ccu_page_out(pc), .sys_page_out(ps));
  spx_core u_spx_core(.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus_if), .req_in(req),
    .kind_in(kind), .mod_in(mod), .data_in(data), .busy_out(busy), .done_out(done),
    .rdata_out(rdo));
  spx_checker u_spx_checker(.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_en(bus_if.wr_en),
    .rd_en(bus_if.rd_en), .mod_sel(bus_if.mod_sel), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata), .map_wr(bus_if.map_wr), .map_wdata(bus_if.map_wdata),
    .map_sel(bus_if.map_sel));
  // one request, wait for done
  task automatic op(input logic [1:0] k, input int m, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    req <= 1'b1; kind <= k; mod <= 2'(m); data <= d;
    @(posedge clk_in);
    req <= 1'b0;
    n = 0;
    do begin @(posedge clk_in); #1; n++; end while (done !== 1'b1 && n < 9);
    if (n >= 9) begin
      miscompares++;
      close_out();
    end
    `CHK(busy, 1'b0)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #40000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1 `CHK({pv, map}, 13'h0)
    $display("reset test done");
    for (int s = 0; s < 4; s++) begin
      op(0, 1, {5'h0, 3'(s + 2)});
      op(0, 1, {2'b10, 2'(s), 1'b1, 3'(7 - s)});
      `CHK(pa, 3'(7 - s))
    end
    $display("save test done");
    for (int m = 0; m < 4; m++) begin
      op(0, m, {1'b0, m[0], 2'h3, 1'b1, 3'(m + 1)});
      `CHK(pv[m*3+:3], 3'(m + 1))
      op(1, m, 8'h0);
      `CHK(rdo, 8'(m + 1))
    end
    $display("plain write test done");
    for (int s = 3; s >= 0; s--) begin
      op(0, 1, {2'b11, 2'(s), 4'h7});
      `CHK(pa, 3'(s + 2))
      op(1, 1, 8'h0);
      `CHK(rdo, 8'(s + 2))
    end
    $display("restore test done");
    op(2, 0, 8'h0);
    repeat (5) @(posedge clk_in);
    `CHK(map, 1'b1)
    op(3, 0, 8'h0);
    `CHK({map, bus_if.map_sel}, 2'b00)
    $display("select test done");
    close_out();
  end
endmodule
`default_nettype wire
